//--- cis_core.sv
/*
  Instruction execution core: one decoded operation per cycle, with its
  register file, product/quotient register and coprocessor accumulator.
  Assumes fetch supplies popped stack words in req.data/req.imm and
  consumes push, jump and length answers one cycle after each request.
*/
`timescale 1ns/10ps
`default_nettype none
module cis_core #(
  parameter int GPR_N = 16
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire cis_pkg::cis_req_t req,
  output var  cis_pkg::cis_rsp_t rsp,
  output var  logic [31:0]  md,
  output var  logic [39:0]  acc
);
  import cis_pkg::*;

  typedef struct packed {
    logic [GPR_N-1:0][DW-1:0] general_purpose_reg;
    logic [2*DW-1:0]          pq;
    logic [ACC_W-1:0]         acc;
    cis_rsp_t                 rsp;
  } cis_state_t;

  cis_state_t s_q;
  cis_state_t s_d;

  // Encoding length per operation
  function automatic logic [LEN_W-1:0] enc_len(cis_op_t op, logic long_enc);
    case (op)
      SUM_OP, SUM_WITH_CARRY_OP, COMPARE_THEN_DECREMENT, COMPARE_THEN_INCREMENT,
      BYTE_EXTEND_MOVE_OP: enc_len = long_enc ? LEN_LONG : LEN_SHORT;
      MASKED_BYTE_FIELD_OP, BIT_COPY_OP, BRANCH_IF_BIT_ONE, BRANCH_IF_BIT_ZERO,
      PUSH_THEN_CALL_OP, CONTEXT_SWITCH_OP, COPROC_MULTIPLY_ACCUMULATE,
      COPROC_ABSOLUTE_ROUND, LEGACY_SLEEP_OPCODE: enc_len = LEN_LONG;
      default: enc_len = LEN_SHORT;
    endcase
  endfunction

  // Shifts until the top bit is one; zero word needs none
  function automatic logic [CNT_W-1:0] norm_count(logic [DW-1:0] w);
    logic found;
    found      = 1'b0;
    norm_count = '0;
    for (int i = DW - 1; i >= 0; i--) begin
      if (!found && w[i]) begin
        norm_count = CNT_W'(DW - 1 - i);
        found      = 1'b1;
      end
    end
  endfunction

  // Relative branch target from a signed word displacement
  function automatic logic [DW-1:0] rel_target(logic [DW-1:0] ip, logic [BW-1:0] disp);
    logic [DW-1:0] off;
    off        = {{(DW-BW){disp[BW-1]}}, disp} << DISP_SHIFT;
    rel_target = DW'(ip + off);
  endfunction

  // Operand selection
  logic [DW-1:0]        op_a;
  logic [DW-1:0]        op_b;
  logic [DW-1:0]        reg_b;
  logic                 cin;
  logic [DW:0]          sum_w;
  logic [BW:0]          sum_b;
  logic signed [2*DW-1:0] prod_s;
  logic [2*DW-1:0]      prod_u;
  logic [DW-1:0]        product_quotient_low_reg;
  logic                 div_zero;
  logic signed [DW-1:0] sq_s;
  logic signed [DW-1:0] sr_s;
  logic [DW-1:0]        sq_u;
  logic [DW-1:0]        sr_u;
  logic signed [2*DW-1:0] lq_s;
  logic signed [2*DW-1:0] lr_s;
  logic [2*DW-1:0]      lq_u;
  logic [2*DW-1:0]      lr_u;
  logic [BW-1:0]        ext_src;
  logic [DW-1:0]        step;
  logic                 test_bit;
  logic [ACC_W-1:0]     acc_prod;

  assign op_a     = s_q.general_purpose_reg[req.rd];
  assign reg_b    = s_q.general_purpose_reg[req.rs];
  assign op_b     = req.long_enc ? req.imm : reg_b;
  assign cin      = (req.op == SUM_WITH_CARRY_OP) && s_q.rsp.flags.c;
  assign sum_w    = {1'b0, op_a} + {1'b0, op_b} + {{DW{1'b0}}, cin};
  assign sum_b    = {1'b0, op_a[BW-1:0]} + {1'b0, op_b[BW-1:0]} + {{BW{1'b0}}, cin};
  assign prod_s   = $signed(op_a) * $signed(reg_b);
  assign prod_u   = op_a * reg_b;
  assign product_quotient_low_reg      = s_q.pq[DW-1:0];
  assign div_zero = (reg_b == ZERO_WORD);
  // Signed zero arm: an unsigned arm would turn the signed divides unsigned
  assign sq_s     = div_zero ? $signed(ZERO_WORD) : $signed(product_quotient_low_reg) / $signed(reg_b);
  assign sr_s     = div_zero ? $signed(ZERO_WORD) : $signed(product_quotient_low_reg) % $signed(reg_b);
  assign sq_u     = div_zero ? '0 : product_quotient_low_reg / reg_b;
  assign sr_u     = div_zero ? '0 : product_quotient_low_reg % reg_b;
  assign lq_s     = div_zero ? $signed({ZERO_WORD, ZERO_WORD})
                             : $signed(s_q.pq) / $signed({{DW{reg_b[DW-1]}}, reg_b});
  assign lr_s     = div_zero ? $signed({ZERO_WORD, ZERO_WORD})
                             : $signed(s_q.pq) % $signed({{DW{reg_b[DW-1]}}, reg_b});
  assign lq_u     = div_zero ? '0 : s_q.pq / {ZERO_WORD, reg_b};
  assign lr_u     = div_zero ? '0 : s_q.pq % {ZERO_WORD, reg_b};
  assign ext_src  = req.long_enc ? req.imm[BW-1:0] : reg_b[BW-1:0];
  assign step     = req.alt ? STEP_TWO : STEP_ONE;
  assign test_bit = op_a[req.bit_d];
  assign acc_prod = {{(ACC_W-2*DW){prod_s[2*DW-1]}}, prod_s};

  // Next state: execute one request per cycle
  always_comb begin
    s_d               = s_q;
    s_d.rsp.done      = 1'b0;
    s_d.rsp.jump      = 1'b0;
    s_d.rsp.push      = 1'b0;
    s_d.rsp.len       = s_q.rsp.len;
    if (req.valid) begin
      s_d.rsp.done = 1'b1;
      s_d.rsp.len  = enc_len(req.op, req.long_enc);
      case (req.op)
        SUM_OP, SUM_WITH_CARRY_OP: begin
          if (req.byte_mode) begin
            s_d.general_purpose_reg[req.rd][BW-1:0] = sum_b[BW-1:0];
            s_d.rsp.result  = {op_a[DW-1:BW], sum_b[BW-1:0]};
            s_d.rsp.flags.c = sum_b[BW];
            s_d.rsp.flags.n = sum_b[BW-1];
            s_d.rsp.flags.z = (sum_b[BW-1:0] == ZERO_BYTE);
            s_d.rsp.flags.v = (op_a[BW-1] == op_b[BW-1]) && (sum_b[BW-1] != op_a[BW-1]);
          end else begin
            s_d.general_purpose_reg[req.rd] = sum_w[DW-1:0];
            s_d.rsp.result  = sum_w[DW-1:0];
            s_d.rsp.flags.c = sum_w[DW];
            s_d.rsp.flags.n = sum_w[DW-1];
            s_d.rsp.flags.z = (sum_w[DW-1:0] == ZERO_WORD);
            s_d.rsp.flags.v = (op_a[DW-1] == op_b[DW-1]) && (sum_w[DW-1] != op_a[DW-1]);
          end
        end
        PRODUCT_OP: begin
          s_d.pq          = req.alt ? prod_u : prod_s;
          s_d.rsp.flags.z = req.alt ? (prod_u == '0) : (prod_s == '0);
          s_d.rsp.flags.n = !req.alt && prod_s[2*DW-1];
          s_d.rsp.flags.v = 1'b0;
        end
        SHORT_QUOTIENT_OP: begin
          // Division by zero leaves the register alone and flags overflow
          s_d.rsp.flags.v = div_zero;
          if (!div_zero) begin
            s_d.pq = req.alt ? {sr_u, sq_u} : {sr_s, sq_s};
          end
        end
        LONG_QUOTIENT_OP: begin
          s_d.rsp.flags.v = div_zero;
          if (!div_zero) begin
            s_d.pq = req.alt ? {lr_u[DW-1:0], lq_u[DW-1:0]}
                             : {lr_s[DW-1:0], lq_s[DW-1:0]};
          end
        end
        COMPARE_THEN_DECREMENT, COMPARE_THEN_INCREMENT: begin
          // Flags come from the compare, before the register steps
          s_d.rsp.result  = DW'(op_a - op_b);
          s_d.rsp.flags.z = (op_a == op_b);
          s_d.rsp.flags.c = (op_a < op_b);
          s_d.rsp.flags.n = s_d.rsp.result[DW-1];
          s_d.rsp.flags.v = (op_a[DW-1] != op_b[DW-1]) && (s_d.rsp.result[DW-1] != op_a[DW-1]);
          if (req.op == COMPARE_THEN_DECREMENT) begin
            s_d.general_purpose_reg[req.rd] = DW'(op_a - step);
          end else begin
            s_d.general_purpose_reg[req.rd] = DW'(op_a + step);
          end
        end
        NORMALIZE_COUNT_OP: begin
          s_d.general_purpose_reg[req.rd] = {{(DW-CNT_W){1'b0}}, norm_count(reg_b)};
          s_d.rsp.flags.z = (reg_b == ZERO_WORD);
        end
        SIGN_RIGHT_SHIFT_OP: begin
          // Shift count is the low four bits of the source register
          s_d.general_purpose_reg[req.rd] = DW'($signed(op_a) >>> reg_b[BIT_W-1:0]);
          s_d.rsp.flags.n = op_a[DW-1];
        end
        MASKED_BYTE_FIELD_OP: begin
          // Mask in imm low byte, new bits in imm high byte
          if (req.alt) begin
            s_d.general_purpose_reg[req.rd][DW-1:BW] = (op_a[DW-1:BW] & ~req.imm[BW-1:0])
                                     | (req.imm[DW-1:BW] & req.imm[BW-1:0]);
          end else begin
            s_d.general_purpose_reg[req.rd][BW-1:0] = (op_a[BW-1:0] & ~req.imm[BW-1:0])
                                    | (req.imm[DW-1:BW] & req.imm[BW-1:0]);
          end
        end
        BIT_COPY_OP: begin
          s_d.general_purpose_reg[req.rd][req.bit_d] = reg_b[req.bit_s] ^ req.alt;
        end
        BYTE_EXTEND_MOVE_OP: begin
          s_d.general_purpose_reg[req.rd] = {(req.alt ? ZERO_BYTE : {BW{ext_src[BW-1]}}), ext_src};
          s_d.rsp.flags.n = !req.alt && ext_src[BW-1];
          s_d.rsp.flags.z = (ext_src == ZERO_BYTE);
        end
        BRANCH_IF_BIT_ONE: begin
          if (test_bit) begin
            s_d.rsp.jump   = 1'b1;
            s_d.rsp.target = rel_target(req.ip, req.imm[BW-1:0]);
            if (req.alt) begin
              s_d.general_purpose_reg[req.rd][req.bit_d] = 1'b0;
            end
          end
        end
        BRANCH_IF_BIT_ZERO: begin
          if (!test_bit) begin
            s_d.rsp.jump   = 1'b1;
            s_d.rsp.target = rel_target(req.ip, req.imm[BW-1:0]);
            if (req.alt) begin
              s_d.general_purpose_reg[req.rd][req.bit_d] = 1'b1;
            end
          end
        end
        PUSH_THEN_CALL_OP: begin
          s_d.rsp.push      = 1'b1;
          s_d.rsp.push_data = op_a;
          s_d.rsp.jump      = 1'b1;
          s_d.rsp.target    = req.imm;
        end
        CONTEXT_SWITCH_OP: begin
          s_d.rsp.push      = 1'b1;
          s_d.rsp.push_data = op_a;
          s_d.general_purpose_reg[req.rd]   = req.imm;
        end
        NEAR_RETURN_OP: begin
          // Fetch hands in the popped return address and, for pop, the word
          s_d.rsp.jump   = 1'b1;
          s_d.rsp.target = req.data;
          if (req.alt) begin
            s_d.general_purpose_reg[req.rd] = req.imm;
          end
        end
        TRAP_OP: begin
          s_d.rsp.push      = 1'b1;
          s_d.rsp.push_data = req.ip;
          s_d.rsp.jump      = 1'b1;
          s_d.rsp.target    = DW'({{(DW-7){1'b0}}, req.imm[6:0]} << TRAP_SHIFT);
        end
        COPROC_MULTIPLY_ACCUMULATE: begin
          s_d.acc = req.alt ? ACC_W'(s_q.acc + acc_prod) : acc_prod;
        end
        COPROC_ABSOLUTE_ROUND: begin
          if (req.alt) begin
            s_d.acc = ACC_W'(s_q.acc + RND_ADD) & RND_MASK;
          end else if (s_q.acc[ACC_W-1]) begin
            s_d.acc = ACC_W'(-s_q.acc);
          end
        end
        default: begin
          // Sleep and null operation: accepted, nothing changes
          s_d.rsp.len = enc_len(req.op, req.long_enc);
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register
  assign rsp = s_q.rsp;
  assign md  = s_q.pq;
  assign acc = s_q.acc;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence seq_push_call;
    req.valid && req.op == PUSH_THEN_CALL_OP;
  endsequence

  sequence seq_push_then_jump;
    rsp.push && rsp.jump;
  endsequence

  chk_len_report: assert property (req.valid |=> rsp.done &&
      rsp.len == $past(enc_len(req.op, req.long_enc)) && (rsp.len == LEN_SHORT || rsp.len == LEN_LONG))
    else $error("length answer wrong");

  chk_sleep_noop: assert property (req.valid && req.op == LEGACY_SLEEP_OPCODE |=>
      $stable(s_q.general_purpose_reg) && $stable(md) && $stable(acc) && !rsp.jump && !rsp.push && rsp.len == LEN_LONG)
    else $error("sleep opcode changed state");

  chk_mul_signed: assert property (req.valid && req.op == PRODUCT_OP && !req.alt |=>
      $signed(md) == $signed($past(op_a)) * $signed($past(reg_b)))
    else $error("signed product wrong");

  chk_cmpd_step: assert property (req.valid && req.op == COMPARE_THEN_DECREMENT && req.rd != req.rs |=>
      s_q.general_purpose_reg[$past(req.rd)] == DW'($past(op_a) - ($past(req.alt) ? STEP_TWO : STEP_ONE)))
    else $error("decrement step wrong");

  chk_cmpi_step: assert property (req.valid && req.op == COMPARE_THEN_INCREMENT |=>
      s_q.general_purpose_reg[$past(req.rd)] == DW'($past(op_a) + ($past(req.alt) ? STEP_TWO : STEP_ONE)))
    else $error("increment step wrong");

  chk_sign_right_shift_op_sign: assert property (req.valid && req.op == SIGN_RIGHT_SHIFT_OP |=>
      s_q.general_purpose_reg[$past(req.rd)][DW-1] == $past(op_a[DW-1]))
    else $error("sign bit lost in shift");

  chk_push_then_call_op_order: assert property (seq_push_call |=> seq_push_then_jump ##0
      rsp.push_data == $past(op_a) && rsp.target == $past(req.imm))
    else $error("push and call mismatch");

  chk_jb_clear: assert property (req.valid && req.op == BRANCH_IF_BIT_ONE && req.alt && test_bit |=>
      rsp.jump && !s_q.general_purpose_reg[$past(req.rd)][$past(req.bit_d)])
    else $error("bit not cleared on branch");

  chk_ret_target: assert property (req.valid && req.op == NEAR_RETURN_OP |=>
      rsp.jump && rsp.target == $past(req.data) ##1 !rsp.jump || $past(req.valid))
    else $error("return address wrong");

endmodule
`default_nettype wire

//--- cis_pkg.sv
/*
  Shared definitions for the instruction execution core: widths, encoding
  lengths, operation codes and the request/response carriers.
  Assumes the fetch unit has already turned raw opcodes into cis_op_t values.
*/
`default_nettype none
package cis_pkg;

  // Datapath sizes
  localparam int DW     = 16;
  localparam int BW     = 8;
  localparam int IDX_W  = 4;
  localparam int BIT_W  = 4;
  localparam int ACC_W  = 40;
  localparam int LEN_W  = 3;
  localparam int CNT_W  = 5;

  // Encoding lengths in bytes
  localparam logic [LEN_W-1:0] LEN_SHORT = 3'h2;
  localparam logic [LEN_W-1:0] LEN_LONG  = 3'h4;

  // Arithmetic constants
  localparam logic [DW-1:0]    STEP_ONE  = 16'h0001;
  localparam logic [DW-1:0]    STEP_TWO  = 16'h0002;
  localparam logic [DW-1:0]    ZERO_WORD = 16'h0000;
  localparam logic [BW-1:0]    ZERO_BYTE = 8'h00;
  localparam logic [BW-1:0]    ONES_BYTE = 8'hFF;
  localparam logic [ACC_W-1:0] RND_ADD   = 40'h00_0000_8000;
  localparam logic [ACC_W-1:0] RND_MASK  = 40'hFF_FFFF_0000;
  localparam int               DISP_SHIFT = 1;   // Relative offsets count words
  localparam int               TRAP_SHIFT = 2;   // Trap vectors are 4 bytes apart

  // Decoded operations; alt selects the documented variant of each operation that has one
  typedef enum logic [4:0] {
    NO_OP, SUM_OP, SUM_WITH_CARRY_OP, PRODUCT_OP, SHORT_QUOTIENT_OP,
    LONG_QUOTIENT_OP, COMPARE_THEN_DECREMENT, COMPARE_THEN_INCREMENT,
    NORMALIZE_COUNT_OP, SIGN_RIGHT_SHIFT_OP, MASKED_BYTE_FIELD_OP,
    BIT_COPY_OP, BYTE_EXTEND_MOVE_OP, BRANCH_IF_BIT_ONE, BRANCH_IF_BIT_ZERO,
    PUSH_THEN_CALL_OP, CONTEXT_SWITCH_OP, NEAR_RETURN_OP, TRAP_OP,
    COPROC_MULTIPLY_ACCUMULATE, COPROC_ABSOLUTE_ROUND, LEGACY_SLEEP_OPCODE
  } cis_op_t;

  typedef struct packed {
    logic n;
    logic c;
    logic v;
    logic z;
  } cis_flags_t;

  typedef struct packed {
    logic             valid;
    cis_op_t          op;
    logic             byte_mode;
    logic             alt;
    logic             long_enc;
    logic [IDX_W-1:0] rd;
    logic [IDX_W-1:0] rs;
    logic [BIT_W-1:0] bit_d;
    logic [BIT_W-1:0] bit_s;
    logic [DW-1:0]    imm;
    logic [DW-1:0]    data;
    logic [DW-1:0]    ip;
  } cis_req_t;

  typedef struct packed {
    logic             done;
    logic [LEN_W-1:0] len;
    cis_flags_t       flags;
    logic [DW-1:0]    result;
    logic             jump;
    logic [DW-1:0]    target;
    logic             push;
    logic [DW-1:0]    push_data;
  } cis_rsp_t;

endpackage
`default_nettype wire

//--- cis_fetch_model.sv
/*
  Fetch-side model: follows the core's answers to track the next address.
  Assumes one answer for each done pulse, registered on the rising edge.
*/
`timescale 1ns/10ps
`default_nettype none
module cis_fetch_model (
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire cis_pkg::cis_rsp_t rsp,
  output var  logic [15:0]       ip_q
);
  import cis_pkg::*;

  // Step by the reported length, or follow a jump
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ip_q <= 16'h0000;
    end else if (rsp.done) begin
      ip_q <= rsp.jump ? rsp.target : ip_q + {13'h0000, rsp.len};
    end
  end
endmodule
`default_nettype wire

//--- cis_core_tb.sv
/*
  Self-checking bench for the execution core, one task per scenario.
  Assumes an answer within a few cycles; registers are seen via pushes.
*/
`timescale 1ns/10ps
`default_nettype none
module cis_core_tb;
  import cis_pkg::*;
  logic        clk;
  logic        rstn;
  cis_req_t    req;
  cis_rsp_t    rsp;
  cis_rsp_t    r;
  logic [31:0] md;
  logic [39:0] acc;
  logic [15:0] ip_q;
  logic [15:0] ip0;
  int          mismatches;
  int          n_compared;

  // Clock, 25 ns period
  always #12.5 clk = ~clk;

  cis_core dut (.clk(clk), .rstn(rstn), .req(req), .rsp(rsp), .md(md), .acc(acc));
  cis_fetch_model fm (.clk(clk), .rstn(rstn), .rsp(rsp), .ip_q(ip_q));

  // Compare and count
  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  // Verdict and end of run
  task automatic wrap_up();
    $display("compared %0d, mismatched %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Build a request with the common fields
  function automatic cis_req_t mk(cis_op_t o, logic a, logic [3:0] d, logic [3:0] s,
                                  logic [15:0] i);
    cis_req_t q;
    q = '0;
    q.valid = 1'b1;
    q.op = o;
    q.alt = a;
    q.rd = d;
    q.rs = s;
    q.imm = i;
    q.ip = 16'h0100;
    return q;
  endfunction

  // One request for one cycle, then a bounded wait for done
  task automatic send(input cis_req_t q);
    int n;
    @(negedge clk);
    req = q;
    @(negedge clk);
    req = '0;
    n = 0;
    while (rsp.done !== 1'b1 && n < 4) begin
      @(negedge clk);
      n++;
    end
    if (rsp.done !== 1'b1) begin
      mismatches++;
      $display("unexpected at %0t: no answer", $time);
      wrap_up();
    end
    r = rsp;
  endtask

  // Register load and readback, both by context switch
  task automatic wr(input logic [3:0] d, input logic [15:0] v);
    send(mk(CONTEXT_SWITCH_OP, 1'b0, d, 4'h0, v));
  endtask
  task automatic chk_reg(input logic [3:0] d, input logic [15:0] v);
    send(mk(CONTEXT_SWITCH_OP, 1'b0, d, 4'h0, 16'h0000));
    chk(r.push_data, v);
  endtask

  // Word add with carry out, then long form with carry in
  task automatic t_sum();
    cis_req_t q;
    wr(4'h1, 16'hFFFF);
    wr(4'h2, 16'h0001);
    send(mk(SUM_OP, 1'b0, 4'h1, 4'h2, 16'h0000));
    chk(r.len, LEN_SHORT);
    chk({r.flags.c, r.flags.z}, 2'b11);
    q = mk(SUM_WITH_CARRY_OP, 1'b0, 4'h1, 4'h0, 16'h0010);
    q.long_enc = 1'b1;
    send(q);
    chk(r.len, LEN_LONG);
    chk_reg(4'h1, 16'h0011);
    wr(4'h3, 16'h12F0);
    q = mk(SUM_OP, 1'b0, 4'h3, 4'h0, 16'h0020);
    q.long_enc = 1'b1;
    q.byte_mode = 1'b1;
    send(q);
    chk({r.result, r.flags.c}, {16'h1210, 1'b1});
    $display("sum test done");
  endtask

  // Multiply signed and unsigned, long and short divide, zero divisor
  task automatic t_muldiv();
    wr(4'h1, 16'hFFFE);
    wr(4'h2, 16'h0003);
    wr(4'h3, 16'h0010);
    wr(4'h4, 16'h0000);
    send(mk(PRODUCT_OP, 1'b0, 4'h1, 4'h2, 16'h0000));
    chk(md, 32'hFFFF_FFFA);
    chk(r.len, LEN_SHORT);
    send(mk(PRODUCT_OP, 1'b1, 4'h1, 4'h2, 16'h0000));
    chk(md, 32'h0002_FFFA);
    send(mk(LONG_QUOTIENT_OP, 1'b1, 4'h0, 4'h3, 16'h0000));
    chk(md, 32'h000A_2FFF);
    send(mk(SHORT_QUOTIENT_OP, 1'b1, 4'h0, 4'h3, 16'h0000));
    chk(md, 32'h000F_02FF);
    send(mk(SHORT_QUOTIENT_OP, 1'b1, 4'h0, 4'h4, 16'h0000));
    chk({md, 7'h00, r.flags.v}, {32'h000F_02FF, 8'h01});
    send(mk(PRODUCT_OP, 1'b0, 4'h1, 4'h2, 16'h0000));
    send(mk(LONG_QUOTIENT_OP, 1'b0, 4'h0, 4'h2, 16'h0000));
    chk(md, 32'h0000_FFFE);
    send(mk(SHORT_QUOTIENT_OP, 1'b0, 4'h0, 4'h2, 16'h0000));
    chk(md, 32'hFFFE_0000);
    $display("multiply and divide test done");
  endtask

  // Compare then step by one or two, each direction
  task automatic t_cmp();
    cis_req_t q;
    wr(4'h5, 16'h0010);
    send(mk(COMPARE_THEN_DECREMENT, 1'b0, 4'h5, 4'h0, 16'h0000));
    chk_reg(4'h5, 16'h000F);
    q = mk(COMPARE_THEN_DECREMENT, 1'b1, 4'h5, 4'h0, 16'h0000);
    q.long_enc = 1'b1;
    send(q);
    chk(r.len, LEN_LONG);
    chk(r.flags.z, 1'b1);
    chk_reg(4'h5, 16'hFFFE);
    send(mk(COMPARE_THEN_INCREMENT, 1'b1, 4'h5, 4'h0, 16'h0000));
    chk_reg(4'h5, 16'h0002);
    send(mk(COMPARE_THEN_INCREMENT, 1'b0, 4'h5, 4'h0, 16'h0000));
    chk_reg(4'h5, 16'h0001);
    $display("compare test done");
  endtask

  // Normalize count, sign shift, byte widening
  task automatic t_alu();
    cis_req_t q;
    wr(4'h6, 16'h0010);
    send(mk(NORMALIZE_COUNT_OP, 1'b0, 4'h7, 4'h6, 16'h0000));
    chk_reg(4'h7, 16'h000B);
    wr(4'h8, 16'h8400);
    wr(4'h9, 16'h0004);
    send(mk(SIGN_RIGHT_SHIFT_OP, 1'b0, 4'h8, 4'h9, 16'h0000));
    chk_reg(4'h8, 16'hF840);
    q = mk(BYTE_EXTEND_MOVE_OP, 1'b0, 4'hA, 4'h0, 16'h0085);
    q.long_enc = 1'b1;
    send(q);
    chk(r.len, LEN_LONG);
    chk_reg(4'hA, 16'hFF85);
    wr(4'hB, 16'h1285);
    send(mk(BYTE_EXTEND_MOVE_OP, 1'b1, 4'hA, 4'hB, 16'h0000));
    chk(r.len, LEN_SHORT);
    chk_reg(4'hA, 16'h0085);
    $display("shift and extend test done");
  endtask

  // Masked byte fields, bit copies, bit branches
  task automatic t_bits();
    cis_req_t q;
    wr(4'hA, 16'h1234);
    send(mk(MASKED_BYTE_FIELD_OP, 1'b1, 4'hA, 4'h0, 16'hA0F0));
    chk(r.len, LEN_LONG);
    send(mk(MASKED_BYTE_FIELD_OP, 1'b0, 4'hA, 4'h0, 16'h550F));
    chk_reg(4'hA, 16'hA235);
    wr(4'hB, 16'h0001);
    wr(4'hC, 16'h0000);
    q = mk(BIT_COPY_OP, 1'b0, 4'hC, 4'hB, 16'h0000);
    q.bit_d = 4'h3;
    send(q);
    q.alt = 1'b1;
    q.bit_d = 4'h4;
    q.bit_s = 4'h1;
    send(q);
    chk(r.len, LEN_LONG);
    chk_reg(4'hC, 16'h0018);
    wr(4'hD, 16'h0004);
    q = mk(BRANCH_IF_BIT_ONE, 1'b1, 4'hD, 4'h0, 16'h00FE);
    q.bit_d = 4'h2;
    send(q);
    chk({r.jump, r.target, r.len}, {1'b1, 16'h00FC, LEN_LONG});
    q.alt = 1'b0;
    send(q);
    chk(r.jump, 1'b0);
    q.op = BRANCH_IF_BIT_ZERO;
    q.alt = 1'b1;
    q.imm = 16'h0005;
    send(q);
    chk({r.jump, r.target}, {1'b1, 16'h010A});
    chk_reg(4'hD, 16'h0004);
    $display("bit test done");
  endtask

  // Push and call, context switch, returns, trap
  task automatic t_stack();
    cis_req_t q;
    wr(4'h1, 16'h1111);
    send(mk(PUSH_THEN_CALL_OP, 1'b0, 4'h1, 4'h0, 16'h2000));
    chk({r.push, r.jump, r.push_data, r.target}, {2'b11, 32'h1111_2000});
    chk(r.len, LEN_LONG);
    send(mk(CONTEXT_SWITCH_OP, 1'b0, 4'h1, 4'h0, 16'h2222));
    chk({r.push, r.push_data, r.len}, {1'b1, 16'h1111, LEN_LONG});
    chk_reg(4'h1, 16'h2222);
    q = mk(NEAR_RETURN_OP, 1'b1, 4'h2, 4'h0, 16'h5555);
    q.data = 16'h3000;
    send(q);
    chk({r.jump, r.target, r.len}, {1'b1, 16'h3000, LEN_SHORT});
    chk_reg(4'h2, 16'h5555);
    q.alt = 1'b0;
    q.data = 16'h3100;
    send(q);
    chk(r.target, 16'h3100);
    chk_reg(4'h2, 16'h0000);
    send(mk(TRAP_OP, 1'b0, 4'h0, 4'h0, 16'h0012));
    chk({r.push, r.push_data, r.target}, {1'b1, 32'h0100_0048});
    chk(r.len, LEN_SHORT);
    @(negedge clk);
    chk(ip_q, 16'h0048);
    $display("stack test done");
  endtask

  // Accumulate, absolute value, rounding, then the sleep opcode
  task automatic t_coproc();
    logic [31:0] md0;
    wr(4'h1, 16'hFFFD);
    wr(4'h2, 16'h0005);
    wr(4'h3, 16'h0100);
    send(mk(COPROC_MULTIPLY_ACCUMULATE, 1'b0, 4'h1, 4'h2, 16'h0000));
    chk({acc, r.len}, {40'hFF_FFFF_FFF1, LEN_LONG});
    send(mk(COPROC_MULTIPLY_ACCUMULATE, 1'b1, 4'h1, 4'h2, 16'h0000));
    chk(acc, 40'hFF_FFFF_FFE2);
    send(mk(COPROC_ABSOLUTE_ROUND, 1'b0, 4'h0, 4'h0, 16'h0000));
    chk({acc, r.len}, {40'h00_0000_001E, LEN_LONG});
    send(mk(COPROC_MULTIPLY_ACCUMULATE, 1'b1, 4'h3, 4'h3, 16'h0000));
    chk(acc, 40'h00_0001_001E);
    send(mk(COPROC_ABSOLUTE_ROUND, 1'b1, 4'h0, 4'h0, 16'h0000));
    chk(acc, 40'h00_0001_0000);
    @(negedge clk);
    ip0 = ip_q;
    md0 = md;
    send(mk(LEGACY_SLEEP_OPCODE, 1'b0, 4'h3, 4'h3, 16'h0000));
    chk({acc, md0}, {40'h00_0001_0000, md});
    chk({r.push, r.jump, r.len}, {2'b00, LEN_LONG});
    @(negedge clk);
    chk(ip_q, ip0 + 16'h0004);
    chk_reg(4'h3, 16'h0100);
    send(mk(NO_OP, 1'b0, 4'h3, 4'h3, 16'h0000));
    chk({r.push, r.jump, r.len}, {2'b00, LEN_SHORT});
    $display("coprocessor test done");
  endtask

  // Main sequence
  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    req = '0;
    mismatches = 0;
    n_compared = 0;
    repeat (12) @(negedge clk);
    rstn = 1'b1;
    @(negedge clk);
    chk(md, 32'h0000_0000);
    chk(acc, 40'h00_0000_0000);
    chk({rsp.done, rsp.push, rsp.jump}, 3'h0);
    t_sum();
    t_muldiv();
    t_cmp();
    t_alu();
    t_bits();
    t_stack();
    t_coproc();
    wrap_up();
  end
endmodule
`default_nettype wire
